// >>> lac_controller.sv
`timescale 1ns/1ps
`default_nettype none
module lac_controller
	import lac_pkg::*;
#(
	parameter int KEY_HOLD_CYCLES = KEY_HOLD_CYC,
	parameter int LAMP_TEST_CYCLES = LAMP_TEST_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [NUM_LAMPS-1:0] lampSetIn,
	input wire logic [NUM_LAMPS-1:0] lampAckIn,
	input wire logic [NUM_RELAYS-1:0] relaySetIn,
	input wire logic [NUM_RELAYS-1:0] relayAckIn,
	input wire logic [NUM_TELE-1:0] teleSetIn,
	input wire logic [NUM_SG-1:0] tripSetIn,
	input wire logic [NUM_SG-1:0] trip_release_input,
	input wire logic all_lamps_ack_input,
	input wire logic all_relays_ack_input,
	input wire logic allTeleAckIn,
	input wire logic linkAckIn,
	input wire logic protAlarmIn,
	input wire logic generalAlarmIn,
	input wire logic cancelKeyIn,
	input wire logic warnSetIn,
	output logic [NUM_LAMPS-1:0] lampOut,
	output logic lampTestRed,
	output logic lampTestGreen,
	output logic [NUM_RELAYS-1:0] relayOut,
	output logic [NUM_TELE-1:0] teleOut,
	output logic [NUM_SG-1:0] tripOut,
	output logic statusWarnOut
);
	// Both counters are 24 bits wide, which caps a hold or a test phase at about 1.7 s at this clock.
	localparam logic [23:0] KEY_LAST = 24'(KEY_HOLD_CYCLES - 1);
	localparam logic [23:0] TEST_LAST = 24'(LAMP_TEST_CYCLES - 1);

	lac_state_t q, d;
	lac_pins_t pinsIn;
	lac_pins_t rise;
	logic readyOut;
	logic [NUM_RELAYS-1:0] relayReq;
	logic [NUM_RELAYS-1:0] relayLatched;

	// Address decode for the read path; writes compare the registered wrAddr instead.
	function automatic logic regHit(input logic [31:0] addr, input logic [7:0] ofs);
		regHit = (addr[31:8] == 24'h000000) && (addr[7:0] == ofs);
	endfunction

	// True when the key scope reaches a category whose lowest scope code is given.
	function automatic logic scopeCovers(input logic [2:0] scope, input logic [2:0] lowest);
		scopeCovers = (scope >= lowest) && (scope <= SCOPE_ALL);
	endfunction

	// All pins gathered so one two-stage synchroniser covers them.
	always_comb begin
		pinsIn.lampSet = lampSetIn;
		pinsIn.lampAck = lampAckIn;
		pinsIn.relaySet = relaySetIn;
		pinsIn.relayAck = relayAckIn;
		pinsIn.teleSet = teleSetIn;
		pinsIn.tripSet = tripSetIn;
		pinsIn.tripRelease = trip_release_input;
		pinsIn.allLampsAck = all_lamps_ack_input;
		pinsIn.allRelaysAck = all_relays_ack_input;
		pinsIn.allTeleAck = allTeleAckIn;
		pinsIn.linkAck = linkAckIn;
		pinsIn.protAlarm = protAlarmIn;
		pinsIn.generalAlarm = generalAlarmIn;
		pinsIn.cancelKey = cancelKeyIn;
		pinsIn.warnSet = warnSetIn;
	end

	// Rising edges of the synchronised pins turn held levels into one-cycle requests.
	assign rise = lac_pins_t'(q.s2 & ~q.prev);

	////////////////////////////////////////////////////////////////////////////////
	// Acknowledge logic and register file.

	always_comb begin
		logic remote;
		logic [4:0] cmd;
		logic keyFire;
		logic keyLamp;
		logic keyRelay;
		logic keyAll;
		logic alarmNew;
		logic grpLamp;
		logic grpRelay;
		logic grpTele;
		logic [NUM_LAMPS-1:0] lampReq;
		logic [NUM_LAMPS-1:0] lampClr;
		logic [NUM_SG-1:0] tripClr;
		remote = 1'b0;
		cmd = 5'h00;
		keyFire = 1'b0;
		keyLamp = 1'b0;
		keyRelay = 1'b0;
		keyAll = 1'b0;
		alarmNew = 1'b0;
		grpLamp = 1'b0;
		grpRelay = 1'b0;
		grpTele = 1'b0;
		lampReq = '0;
		lampClr = '0;
		tripClr = '0;
		relayReq = '0;
		d = q;
		d.s1 = pinsIn;
		d.s2 = q.s1;
		d.prev = q.s2;
		remote = q.remoteEn;

		// Bus writes land in the data phase, one cycle after the address was taken.
		// The command register keeps nothing: its bits act only in the cycle the write lands.
		if (q.wrPend) begin
			if (q.wrAddr == OFS_CTRL) begin
				d.remoteEn = hwdata[CTRL_REMOTE];
				d.editMode = hwdata[CTRL_EDIT];
				d.keyScope = hwdata[CTRL_SCOPE+:3];
			end
			if (q.wrAddr == OFS_LAMPCFG) begin
				d.lampLatchEn = hwdata[NUM_LAMPS-1:0];
				d.lampAlarmClr = hwdata[LAMPCFG_ALARM+:NUM_LAMPS];
			end
			if (q.wrAddr == OFS_OFFDLY) begin
				d.offDelay = hwdata[15:0];
			end
			if (q.wrAddr == OFS_CMD) begin
				cmd = hwdata[4:0];
			end
		end

		// A one-second hold fires once per press; editing mode owns the key.
		if (q.s2.cancelKey && !q.editMode) begin
			if (q.keyCnt != KEY_LAST) begin
				d.keyCnt = q.keyCnt + 24'h000001;
			end else if (!q.keyDone) begin
				keyFire = 1'b1;
				d.keyDone = 1'b1;
			end
		end else begin
			d.keyCnt = 24'h000000;
			d.keyDone = 1'b0;
		end
		keyLamp = keyFire && scopeCovers(q.keyScope, SCOPE_LAMPS);
		keyRelay = keyFire && scopeCovers(q.keyScope, SCOPE_RELAYS);
		keyAll = keyFire && scopeCovers(q.keyScope, SCOPE_ALL);

		// Every source but the key is gated by the remote enable.
		alarmNew = rise.protAlarm | rise.generalAlarm;
		grpLamp = (remote & (rise.allLampsAck | cmd[CMD_LAMPS] | cmd[CMD_ALL])) | keyLamp;
		grpRelay = (remote & (rise.allRelaysAck | cmd[CMD_RELAYS] | cmd[CMD_ALL])) | keyRelay;
		grpTele = (remote & (rise.allTeleAck | rise.linkAck | cmd[CMD_TELE] | cmd[CMD_ALL])) | keyAll;

		// Lamps: individual, group and alarm clearing, each needing a dropped source.
		lampReq = {NUM_LAMPS{grpLamp}} | ({NUM_LAMPS{remote}} & rise.lampAck);
		lampReq = lampReq | ({NUM_LAMPS{remote & alarmNew}} & q.lampAlarmClr);
		lampClr = lampReq & ~q.s2.lampSet;
		d.lampQ = (q.lampQ & ~lampClr) | (q.s2.lampSet & q.lampLatchEn);
		d.lampOut = d.lampQ | q.s2.lampSet;

		// Relays: the alarm path never reaches them; release timing is in the relay cell.
		relayReq = {NUM_RELAYS{grpRelay}} | ({NUM_RELAYS{remote}} & rise.relayAck);

		// Telecontrol and trip latches; set wins over a coincident clear.
		d.teleQ = (q.teleQ & ~({NUM_TELE{grpTele}} & ~q.s2.teleSet)) | q.s2.teleSet;
		tripClr = (({NUM_SG{remote}} & (rise.tripRelease | {NUM_SG{cmd[CMD_ALL]}})) | {NUM_SG{keyAll}});
		d.tripQ = (q.tripQ & ~(tripClr & ~q.s2.tripSet)) | q.s2.tripSet;
		d.warnQ = (q.warnQ & ~(remote & cmd[CMD_WARN] & ~q.s2.warnSet)) | q.s2.warnSet;

		// Lamp test: one second red then one second green after any lamp acknowledge.
		case (q.testPh)
			TEST_IDLE: begin
				d.testCnt = 24'h000000;
			end
			TEST_RED: begin
				d.testCnt = q.testCnt + 24'h000001;
				if (q.testCnt == TEST_LAST) begin
					d.testPh = TEST_GREEN;
					d.testCnt = 24'h000000;
				end
			end
			TEST_GREEN: begin
				d.testCnt = q.testCnt + 24'h000001;
				if (q.testCnt == TEST_LAST) begin
					d.testPh = TEST_IDLE;
					d.testCnt = 24'h000000;
				end
			end
			default: begin
				d.testPh = TEST_IDLE;
				d.testCnt = 24'h000000;
			end
		endcase
		if (|lampReq) begin
			d.testPh = TEST_RED;
			d.testCnt = 24'h000000;
		end
		// Colours are kept as flops of their own so the lamp driver sees no decode glitches.
		d.testRed = (d.testPh == TEST_RED);
		d.testGreen = (d.testPh == TEST_GREEN);

		// Address phase: reads are answered from a register in the data phase.
		d.wrPend = 1'b0;
		if (hsel && htrans[1] && hready) begin
			d.wrPend = hwrite;
			d.wrAddr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hff;
			d.rdata = 32'h00000000;
			if (!hwrite) begin
				if (regHit(haddr, OFS_CTRL)) begin
					d.rdata[CTRL_REMOTE] = q.remoteEn;
					d.rdata[CTRL_EDIT] = q.editMode;
					d.rdata[CTRL_SCOPE+:3] = q.keyScope;
				end
				if (regHit(haddr, OFS_LAMPCFG)) begin
					d.rdata[NUM_LAMPS-1:0] = q.lampLatchEn;
					d.rdata[LAMPCFG_ALARM+:NUM_LAMPS] = q.lampAlarmClr;
				end
				if (regHit(haddr, OFS_OFFDLY)) begin
					d.rdata[15:0] = q.offDelay;
				end
				if (regHit(haddr, OFS_LAMPST)) begin
					d.rdata[NUM_LAMPS-1:0] = q.lampQ;
				end
				if (regHit(haddr, OFS_MISCST)) begin
					d.rdata[NUM_RELAYS-1:0] = relayLatched;
					d.rdata[MST_TELE+:NUM_TELE] = q.teleQ;
					d.rdata[MST_TRIP+:NUM_SG] = q.tripQ;
					d.rdata[MST_WARN] = q.warnQ;
					d.rdata[MST_RED] = (q.testPh == TEST_RED);
					d.rdata[MST_GREEN] = (q.testPh == TEST_GREEN);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	// Reset leaves remote acknowledge off so only the panel key works until configured.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.keyScope <= SCOPE_RST;
			q.offDelay <= OFFDLY_RST;
			q.testPh <= TEST_IDLE;
		end else begin
			q <= d;
		end
	end

	// The slave never stalls; ready is a flop held high through reset too, so no master waits on it.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			readyOut <= 1'b1;
		end else begin
			readyOut <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Relay latches, each with its own off-delay timer.

	genvar gi;
	generate
		for (gi = 0; gi < NUM_RELAYS; gi++) begin : gRelay
			lac_relay_latch uRelay (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.setIn(q.s2.relaySet[gi]),
				.ackReq(relayReq[gi]),
				.offDelay(q.offDelay),
				.relayOut(relayLatched[gi])
			);
		end
	endgenerate

	// Outputs are the registered state, except hresp, which is tied low.
	assign hreadyout = readyOut;
	assign hrdata = q.rdata;
	assign hresp = 1'b0;
	assign lampOut = q.lampOut;
	assign lampTestRed = q.testRed;
	assign lampTestGreen = q.testGreen;
	assign relayOut = relayLatched;
	assign teleOut = q.teleQ;
	assign tripOut = q.tripQ;
	assign statusWarnOut = q.warnQ;
endmodule
`default_nettype wire

// >>> lac_pkg.sv
// How it works
// - Latch lamps, relays, telecontrol and trip commands.
// - Clear only once the originating signal drops.
// - Remote disabled leaves only the cancel key.
// - Relay latch releases after its off-delay.
// - Each lamp has its own acknowledge input.
// - Each relay has its own acknowledge input.
// - Each switchgear has a trip-release input.
// - Group inputs clear all lamps, all relays.
// - Group input clears all telecontrol latches.
// - Remote disabled blocks group and link acknowledges.
// - New protection alarm clears lamp latches.
// - Alarm clearing only for lamps configured so.
// - Alarm never clears relays, telecontrol, trips.
// - Collective commands clear whole latch sets.
// - A command clears the status warning.
// - Cancel key performs a collective acknowledge.
// - One second key hold acknowledges immediately.
// - Lamp acknowledge runs red then green test.
// - Parameter editing disables the cancel key.
`default_nettype none
package lac_pkg;
	localparam int NUM_LAMPS = 14;
	localparam int NUM_RELAYS = 8;
	localparam int NUM_TELE = 8;
	localparam int NUM_SG = 4;
	localparam int CLK_HZ = 10000000;
	localparam int KEY_HOLD_MS = 1000;
	localparam int LAMP_TEST_MS = 1000;
	localparam int KEY_HOLD_CYC = KEY_HOLD_MS * (CLK_HZ / 1000);
	localparam int LAMP_TEST_CYC = LAMP_TEST_MS * (CLK_HZ / 1000);
	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LAMPCFG = 8'h04;
	localparam logic [7:0] OFS_CMD = 8'h08;
	localparam logic [7:0] OFS_OFFDLY = 8'h0c;
	localparam logic [7:0] OFS_LAMPST = 8'h10;
	localparam logic [7:0] OFS_MISCST = 8'h14;
	// Control and lamp configuration register fields.
	localparam int CTRL_REMOTE = 0;
	localparam int CTRL_EDIT = 1;
	localparam int CTRL_SCOPE = 2;
	localparam int LAMPCFG_ALARM = 16;
	// Command register bits.
	localparam int CMD_LAMPS = 0;
	localparam int CMD_RELAYS = 1;
	localparam int CMD_TELE = 2;
	localparam int CMD_WARN = 3;
	localparam int CMD_ALL = 4;
	// Miscellaneous status fields.
	localparam int MST_TELE = 8;
	localparam int MST_TRIP = 16;
	localparam int MST_WARN = 20;
	localparam int MST_RED = 21;
	localparam int MST_GREEN = 22;
	// Cancel key scopes.
	localparam logic [2:0] SCOPE_LAMPS = 3'h1;
	localparam logic [2:0] SCOPE_RELAYS = 3'h3;
	localparam logic [2:0] SCOPE_ALL = 3'h4;
	// Reset values.
	localparam logic [2:0] SCOPE_RST = 3'h1;
	localparam logic [15:0] OFFDLY_RST = 16'h0000;
	typedef enum logic [1:0] {TEST_IDLE, TEST_RED, TEST_GREEN} lac_test_t;
	typedef struct packed {
		logic [NUM_LAMPS-1:0] lampSet;
		logic [NUM_LAMPS-1:0] lampAck;
		logic [NUM_RELAYS-1:0] relaySet;
		logic [NUM_RELAYS-1:0] relayAck;
		logic [NUM_TELE-1:0] teleSet;
		logic [NUM_SG-1:0] tripSet;
		logic [NUM_SG-1:0] tripRelease;
		logic allLampsAck;
		logic allRelaysAck;
		logic allTeleAck;
		logic linkAck;
		logic protAlarm;
		logic generalAlarm;
		logic cancelKey;
		logic warnSet;
	} lac_pins_t;
	typedef struct packed {
		logic latched;
		logic pend;
		logic [15:0] cnt;
	} lac_relay_t;
	typedef struct packed {
		lac_pins_t s1;
		lac_pins_t s2;
		lac_pins_t prev;
		logic remoteEn;
		logic editMode;
		logic [2:0] keyScope;
		logic [NUM_LAMPS-1:0] lampLatchEn;
		logic [NUM_LAMPS-1:0] lampAlarmClr;
		logic [15:0] offDelay;
		logic [NUM_LAMPS-1:0] lampQ;
		logic [NUM_LAMPS-1:0] lampOut;
		logic [NUM_TELE-1:0] teleQ;
		logic [NUM_SG-1:0] tripQ;
		logic warnQ;
		logic wrPend;
		logic [7:0] wrAddr;
		logic [31:0] rdata;
		logic [23:0] keyCnt;
		logic keyDone;
		lac_test_t testPh;
		logic [23:0] testCnt;
		logic testRed;
		logic testGreen;
	} lac_state_t;
endpackage
`default_nettype wire

// >>> lac_relay_latch.sv
`timescale 1ns/1ps
`default_nettype none
module lac_relay_latch
	import lac_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic setIn,
	input wire logic ackReq,
	input wire logic [15:0] offDelay,
	output logic relayOut
);
	lac_relay_t q, d;

	// An accepted acknowledge is remembered and released only after the off-delay.
	always_comb begin
		d = q;
		if (setIn) begin
			d.latched = 1'b1;
			d.pend = 1'b0;
			d.cnt = 16'h0000;
		end else begin
			if (ackReq) begin
				d.pend = 1'b1;
			end
			// Counting stops at the delay, so a delay lowered later releases at once instead of after a wrap.
			if (q.cnt < offDelay) begin
				d.cnt = q.cnt + 16'h0001;
			end
			if (d.pend && q.cnt >= offDelay) begin
				d.latched = 1'b0;
				d.pend = 1'b0;
			end
		end
	end

	// Single register stage for the whole relay state.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign relayOut = q.latched;
endmodule
`default_nettype wire

// >>> lac_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lac_checker
	import lac_pkg::*;
#(
	parameter int LAMP_TEST_CYCLES = LAMP_TEST_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [NUM_LAMPS-1:0] lampSetIn,
	input wire logic [NUM_LAMPS-1:0] lampOut,
	input wire logic lampTestRed,
	input wire logic lampTestGreen,
	input wire logic [NUM_RELAYS-1:0] relaySetIn,
	input wire logic [NUM_RELAYS-1:0] relayOut,
	input wire logic [NUM_TELE-1:0] teleSetIn,
	input wire logic [NUM_TELE-1:0] teleOut
);
	logic wp_q;
	logic [7:0] wa_q, hiL_q, hiT_q, red_q, grn_q;
	logic [4:0] ctl_q;
	logic [15:0] off_q, loR_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////
	// Shadow control and off-delay writes; source run lengths saturate so a long idle cannot wrap, colour run lengths wrap.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{wp_q, wa_q, off_q, loR_q, hiL_q, hiT_q, red_q, grn_q} <= '0;
			ctl_q <= 5'h04;
		end else begin
			wp_q <= hsel && htrans[1] && hready && hwrite;
			if (hsel && htrans[1] && hready) begin
				wa_q <= haddr[7:0];
			end
			if (wp_q && wa_q == OFS_CTRL) begin
				ctl_q <= hwdata[4:0];
			end
			if (wp_q && wa_q == OFS_OFFDLY) begin
				off_q <= hwdata[15:0];
			end
			hiL_q <= lampSetIn[0] ? hiL_q + {7'h00, ~&hiL_q} : 8'h00;
			hiT_q <= teleSetIn[0] ? hiT_q + {7'h00, ~&hiT_q} : 8'h00;
			loR_q <= relaySetIn[0] ? 16'h0000 : loR_q + {15'h0000, ~&loR_q};
			red_q <= lampTestRed ? red_q + 8'h01 : 8'h00;
			grn_q <= lampTestGreen ? grn_q + 8'h01 : 8'h00;
		end
	end
	////////////////////////////////
	// A live source always wins over any clear.
	lamp_held_a:
		assert property (hiL_q >= 8'd5 |-> lampOut[0]) else $error("lamp dark");
	tele_held_a:
		assert property (hiT_q >= 8'd5 |-> teleOut[0]) else $error("tele cleared");
	remote_gate_a:
		assert property ($fell(teleOut[0]) |-> ctl_q[0] || ctl_q[4:2] == SCOPE_ALL) else $error("tele gate");
	off_delay_a:
		assert property ($fell(relayOut[0]) |-> loR_q > off_q) else $error("relay early");
	red_len_a:
		assert property ($fell(lampTestRed) |-> lampTestGreen && red_q == LAMP_TEST_CYCLES) else $error("red len");
	green_len_a:
		assert property ($fell(lampTestGreen) |-> grn_q == LAMP_TEST_CYCLES) else $error("green len");
	test_order_a:
		assert property ($rose(lampTestGreen) |-> $past(lampTestRed)) else $error("green first");
	one_colour_a:
		assert property (!(lampTestRed && lampTestGreen)) else $error("two colours");
endmodule
bind lac_controller lac_checker #(.LAMP_TEST_CYCLES(LAMP_TEST_CYCLES)) lac_checker_inst (.ref_clk, .rst_n,
	.hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .lampSetIn, .lampOut, .lampTestRed, .lampTestGreen,
	.relaySetIn, .relayOut, .teleSetIn, .teleOut);
`default_nettype wire

// >>> lac_panel_key.sv
`timescale 1ns/1ps
`default_nettype none
module lac_panel_key (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] holdLen,
	input wire logic press,
	output logic cancelKeyIn
);
	logic [7:0] cnt_q;
	// The operator holds the key for the asked number of cycles, then it springs back.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
		end else if (press) begin
			cnt_q <= holdLen;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
	// The contact is closed only while the count runs.
	assign cancelKeyIn = cnt_q != 8'h00;
endmodule
`default_nettype wire

// >>> test_latch_acknowledge_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_latch_acknowledge_controller
	import lac_pkg::*;
;
	localparam int L = 6;
	localparam int R = 20;
	localparam int T = 28;
	logic ref_clk, rst_n, hsel, hwrite, hreadyout, lampTestRed, lampTestGreen, keyPress, cancelKeyIn;
	logic hresp, statusWarnOut;
	logic [31:0] haddr, hwdata, hrdata, ack;
	logic [1:0] htrans;
	logic [7:0] keyLen, relayOut, teleOut;
	logic [13:0] lampOut;
	logic [3:0] tripOut;
	logic [34:0] src;
	int mismatches, check_count;
	// Short counts keep the hold and lamp-test phases brief.
	lac_controller #(.KEY_HOLD_CYCLES(20), .LAMP_TEST_CYCLES(10)) lac_controller_inst (.ref_clk, .rst_n, .hsel,
		.haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
		.lampSetIn(src[13:0]), .lampAckIn(ack[19:6]), .relaySetIn(src[21:14]), .relayAckIn(ack[27:20]),
		.teleSetIn(src[29:22]), .tripSetIn(src[33:30]), .trip_release_input(ack[31:28]),
		.all_lamps_ack_input(ack[0]), .all_relays_ack_input(ack[1]), .allTeleAckIn(ack[2]), .linkAckIn(ack[3]),
		.protAlarmIn(ack[4]), .generalAlarmIn(ack[5]), .cancelKeyIn, .warnSetIn(src[34]), .lampOut,
		.lampTestRed, .lampTestGreen, .relayOut, .teleOut, .tripOut, .statusWarnOut);
	lac_panel_key lac_panel_key_inst (.ref_clk, .rst_n, .holdLen(keyLen), .press(keyPress), .cancelKeyIn);
	// Free-running clock of 100 ns.
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h, want %h", $time, g, e);
		end
	endtask
	// Wait for ready at a rising edge; a bus that never answers ends the run.
	task automatic rdy;
		int n;
		n = 0;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1 && n <= 50) begin
			n++;
			@(posedge ref_clk);
		end
		if (n > 50) begin
			mismatches++;
			$display("mismatch at %0t: bus stuck", $time);
			tally_and_finish();
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
		chk(32'(hresp), 32'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	// Sources pulse high then drop, so their latches can be cleared.
	task automatic fire(input logic [34:0] m);
		src <= m;
		tick(6);
		src <= '0;
		tick(6);
	endtask
	task automatic hit(input logic [31:0] m);
		ack <= m;
		tick(2);
		ack <= '0;
		tick(5);
	endtask
	task automatic press(input logic [7:0] n);
		keyLen <= n;
		keyPress <= 1'b1;
		tick(1);
		keyPress <= 1'b0;
		tick(int'(n) + 20);
	endtask
	////////////////////////////////
	// Lamp tests are left to finish before the next lamp request.
	initial begin
		logic [31:0] ms [4];
		ms = '{32'h0013ffff, 32'h0013ff00, 32'h00130000, 32'h00030000};
		{rst_n, hsel, hwrite, keyPress, htrans, haddr, hwdata, ack, src, keyLen} = '0;
		mismatches = 0;
		check_count = 0;
		tick(5);
		rst_n <= 1'b1;
		tick(1);
		rd(OFS_CTRL, 32'h4);
		rd(OFS_OFFDLY, 32'h0);
		wr(8'h40, 32'hffffffff);
		rd(8'h40, 32'h0);
		wr(OFS_CTRL, 32'h5);
		wr(OFS_OFFDLY, 32'd30);
		wr(OFS_LAMPCFG, 32'h00013fff);
		fire(35'h3);
		chk(32'(lampOut), 32'h3);
		hit(32'h1 << (L + 1));
		chk(32'(lampOut), 32'h1);
		chk(32'(lampTestRed), 32'h1);
		tick(8);
		chk(32'(lampTestGreen), 32'h1);
		tick(25);
		src <= 35'h1;
		tick(6);
		hit(32'h1 << L);
		src <= '0;
		tick(25);
		chk(32'(lampOut), 32'h1);
		hit(32'h1);
		chk(32'(lampOut), 32'h0);
		tick(25);
		$display("test lamps ended");
		fire(35'h3 | (35'h1 << 14));
		hit(32'h1 << 4);
		chk(32'(lampOut), 32'h2);
		chk(32'(relayOut), 32'h1);
		tick(25);
		fire(35'h1);
		hit(32'h1 << 5);
		chk(32'(lampOut), 32'h2);
		tick(25);
		$display("test alarms ended");
		fire(35'hff << 22);
		wr(OFS_CTRL, 32'h4);
		hit(32'he | (32'h1 << (L + 1)) | (32'h1 << R));
		tick(40);
		chk(32'(relayOut), 32'h1);
		chk(32'(teleOut), 32'hff);
		chk(32'(lampOut), 32'h2);
		wr(OFS_CTRL, 32'h5);
		hit(32'h4);
		chk(32'(teleOut), 32'h0);
		fire(35'hff << 22);
		hit(32'h8);
		chk(32'(teleOut), 32'h0);
		hit(32'h2);
		tick(40);
		chk(32'(relayOut), 32'h0);
		hit(32'h1);
		tick(25);
		$display("test remote ended");
		src <= 35'h3 << 14;
		tick(6);
		src <= '0;
		hit(32'h1 << R);
		tick(8);
		chk(32'(relayOut), 32'h3);
		tick(40);
		chk(32'(relayOut), 32'h2);
		src <= 35'h1 << 15;
		tick(6);
		hit(32'h1 << (R + 1));
		src <= '0;
		tick(45);
		chk(32'(relayOut), 32'h2);
		$display("test off delay ended");
		fire(35'h4ffffffff);
		chk(32'(statusWarnOut), 32'h1);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CMD, 32'h1 << i);
			tick(45);
			rd(OFS_MISCST, ms[i]);
		end
		chk(32'(lampOut), 32'h0);
		chk(32'(statusWarnOut), 32'h0);
		hit(32'h1 << T);
		chk(32'(tripOut), 32'h2);
		wr(OFS_CMD, 32'h1 << CMD_ALL);
		tick(5);
		chk(32'(tripOut), 32'h0);
		$display("test commands ended");
		wr(OFS_CTRL, 32'h4);
		fire(35'h4);
		press(8'd5);
		chk(32'(lampOut), 32'h4);
		press(8'd40);
		chk(32'(lampOut), 32'h0);
		wr(OFS_CTRL, 32'h6);
		fire(35'h4);
		press(8'd40);
		chk(32'(lampOut), 32'h4);
		wr(OFS_CTRL, 32'hc);
		fire(35'h1 << 14);
		press(8'd40);
		chk(32'(relayOut), 32'h0);
		wr(OFS_CTRL, 32'h10);
		fire((35'h1 << 22) | (35'h1 << 30) | 35'h4);
		press(8'd40);
		chk(32'(teleOut), 32'h0);
		chk(32'(lampOut), 32'h0);
		chk(32'(tripOut), 32'h0);
		$display("test cancel key ended");
		tally_and_finish();
	end
endmodule
`default_nettype wire
